// ---- verilog/acl_pkg.sv ----
package acl_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_TIME = 1;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / 1000 * MS_TIME;
  localparam int unsigned FLASH_HALF_MS_DEF = 500;

  localparam logic [7:0] ADDR_STARTER_CFG = 8'h00;
  localparam logic [7:0] ADDR_TYPICAL = 8'h04;
  localparam logic [7:0] ADDR_XFER_DELAY = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_POLARITY = 8'h14;

  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
  localparam logic [31:0] CFG_WMASK = 32'h0000_0f03;
  localparam logic [31:0] CFG_ALLOW_MASK = 32'h0000_0002;
  localparam logic [31:0] TYP_RESET = 32'h0000_0020;
  localparam logic [31:0] TYP_WMASK = 32'h0000_0073;
  localparam logic [31:0] DLY_RESET = 32'h0000_0064;
  localparam logic [31:0] DLY_WMASK = 32'h0000_ffff;
  localparam logic [31:0] POL_WMASK = 32'h0000_07ff;

  localparam logic [3:0] TYPE_NONREV = 4'h0;
  localparam logic [3:0] TYPE_REV = 4'h1;
  localparam int unsigned TGM_LOCAL_BIT = 9;
  localparam int unsigned TGM_REMOTE_BIT = 10;

  localparam int unsigned HWIN_W = 11;
  // active-low pins: stop, emergency stop, safety circuit, external supervision
  localparam logic [10:0] HWIN_DEFAULT_POL = 11'h1e0;

  typedef enum logic [2:0] {
    SRC_FIELDBUS = 3'b000,
    SRC_SERIAL = 3'b001,
    SRC_HARDWIRE = 3'b010,
    SRC_FIXED_LOCAL = 3'b011,
    SRC_FIXED_REMOTE = 3'b100
  } acl_src_e;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_FWD = 2'b01,
    ST_REV = 2'b10,
    ST_XFER = 2'b11
  } acl_state_e;

  typedef struct packed {
    logic run_forward_cmd;
    logic run_reverse_cmd;
    logic stop;
    logic estop;
    logic safety;
    logic ext_sup;
    logic mode_local;
    logic mode_remote;
    logic drawer_sup;
    logic reset_alarm;
    logic ext_fault;
  } acl_hwin_s;

  typedef struct packed {
    logic rly41;
    logic rly43;
    logic rly45;
    logic rly22;
    logic rly23;
    logic rly24;
    logic rly25;
    logic rly26;
  } acl_relay_s;

  typedef struct packed {
    logic [19:0] rsvd1;
    logic [3:0] starter_type;
    logic [5:0] rsvd0;
    logic param_allow;
    logic default_cfg;
  } acl_cfg_s;

  typedef struct packed {
    logic [24:0] rsvd1;
    acl_src_e src;
    logic [1:0] rsvd0;
    logic supv_en;
    logic switch_allow;
  } acl_typ_s;

  typedef struct packed {
    logic [6:0] rsvd3;
    logic identify;
    logic [6:0] rsvd2;
    logic fault_clear;
    logic [5:0] rsvd1;
    logic coil_remote;
    logic coil_local;
    logic [4:0] rsvd0;
    logic stop;
    logic rev;
    logic fwd;
  } acl_cmd_s;

  typedef struct packed {
    logic [22:0] rsvd;
    logic trip;
    logic fault;
    logic conflict;
    logic remote_ok;
    logic local_ok;
    logic drawer_ready;
    logic xfer;
    logic rev;
    logic fwd;
  } acl_status_s;
endpackage

// ---- verilog/acl_starter_ctrl.sv ----
// Operation
// - no contactor energised without drawer ready
// - supervision enabled needs drawer supervision input
// - fieldbus telegram bit 9 local, 10 remote
// - serial coil 10 local, coil 11 remote
// - hardwired mode inputs select local or remote
// - fixed local accepts all local sources
// - fixed remote accepts only remote source
// - local and remote together block drawer ready
// - configuration writes need parameter change allowed
// - forward command closes relay 41 when ready
// - stop command opens forward contactor
// - reverse command closes relay 43 from off
// - direction change only with switchover allowed
// - switchover stops, waits delay, then reverses
// - type 0x1 with default selects reversing map
// - run inputs high, stop-type inputs low active
// - small variant relays 41, 43, 45
// - relay 45 warning steady, failure flashing; small variant shows failure steady, large reversing map shows run
// - relay 25 ready steady, identify flashing
// - no default config lets user remap inputs
// - type 0x0 with default selects single direction
//
// Our own choices: register access over Wishbone and the placing of the registers.
module acl_starter_ctrl #(
  parameter int unsigned MS_CYCLES = acl_pkg::MS_CYCLES_DEF,
  parameter int unsigned FLASH_HALF_MS = acl_pkg::FLASH_HALF_MS_DEF,
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire acl_pkg::acl_hwin_s hw_pins_i,
  input wire logic [15:0] fieldbus_control_telegram_i,
  input wire logic fieldbus_control_valid_i,
  input wire logic fieldbus_reset_telegram_i,
  input wire logic warning_i,
  output acl_pkg::acl_relay_s relay_o
);
  import acl_pkg::*;

  if (MS_CYCLES < 1 || FLASH_HALF_MS < 1 || FLASH_HALF_MS > 65535) begin : g_chk
    $error("acl_starter_ctrl: timing parameters out of range");
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] bmask;
    bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    merge = (old_v & ~bmask) | (new_v & bmask);
  endfunction

  acl_cfg_s cfg_reg;
  acl_typ_s typ_reg;
  logic [15:0] delay_reg;
  logic [HWIN_W-1:0] pol_reg;
  logic ident_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [HWIN_W-1:0] sync1_reg;
  logic [HWIN_W-1:0] sync2_reg;
  acl_hwin_s hw_prev_reg;
  logic fb_loc_reg;
  logic fb_rem_reg;
  logic ser_loc_reg;
  logic ser_rem_reg;
  logic fault_reg;
  acl_state_e state_reg;
  acl_state_e state_next;
  acl_state_e tgt_reg;
  acl_state_e tgt_next;
  logic [31:0] xfer_pre_reg;
  logic [15:0] xfer_ms_reg;
  logic [31:0] flash_pre_reg;
  logic [15:0] flash_ms_reg;
  logic flash_reg;
  acl_relay_s relay_reg;
  acl_relay_s relay_next;
  acl_hwin_s hw;
  acl_cmd_s cmd_w;
  acl_status_s status;

  // bus decode, one access per ack
  wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic wb_wr = wb_req & wb_we_i;
  wire logic wr_cfg = wb_wr & (wb_adr_i == ADDR_STARTER_CFG);
  wire logic wr_typ = wb_wr & (wb_adr_i == ADDR_TYPICAL);
  wire logic wr_dly = wb_wr & (wb_adr_i == ADDR_XFER_DELAY);
  wire logic wr_cmd = wb_wr & (wb_adr_i == ADDR_COMMAND);
  wire logic wr_pol = wb_wr & (wb_adr_i == ADDR_POLARITY);
  wire logic cfg_open = cfg_reg.param_allow;
  wire logic [31:0] cfg_merge = merge(cfg_reg, wb_dat_i, wb_sel_i, CFG_WMASK);
  // the allow bit itself stays writable, otherwise the lock could never be lifted
  wire logic [31:0] cfg_wval = cfg_open ? cfg_merge
                             : ((cfg_reg & ~CFG_ALLOW_MASK) | (cfg_merge & CFG_ALLOW_MASK));
  // user mapping only without default config
  wire logic pol_open = cfg_open & ~cfg_reg.default_cfg;
  assign cmd_w = acl_cmd_s'(merge(32'h0000_0000, wb_dat_i, wb_sel_i, 32'hffff_ffff)
                            & {32{wr_cmd}});

  wire logic is_rev_type = (cfg_reg.starter_type == TYPE_REV);
  wire logic [HWIN_W-1:0] pol_mask = cfg_reg.default_cfg ? HWIN_DEFAULT_POL : pol_reg;
  assign hw = acl_hwin_s'(sync2_reg ^ pol_mask);
  wire acl_hwin_s hw_rise = acl_hwin_s'((sync2_reg ^ pol_mask) & ~hw_prev_reg);

  wire logic local_sel = (typ_reg.src == SRC_FIELDBUS) ? fb_loc_reg
                       : (typ_reg.src == SRC_SERIAL) ? ser_loc_reg
                       : (typ_reg.src == SRC_HARDWIRE) ? hw.mode_local
                       : (typ_reg.src == SRC_FIXED_LOCAL);
  wire logic remote_sel = (typ_reg.src == SRC_FIELDBUS) ? fb_rem_reg
                        : (typ_reg.src == SRC_SERIAL) ? ser_rem_reg
                        : (typ_reg.src == SRC_HARDWIRE) ? hw.mode_remote
                        : (typ_reg.src == SRC_FIXED_REMOTE);
  wire logic conflict = local_sel & remote_sel;
  wire logic local_ok = local_sel & ~remote_sel;
  wire logic remote_ok = remote_sel & ~local_sel;

  // an open stop circuit trips a running motor as well as blocking a start
  wire logic trip = hw.stop | hw.estop | hw.safety | hw.ext_sup;
  wire logic drawer_ready = ~fault_reg & ~trip & (~typ_reg.supv_en | hw.drawer_sup)
                          & ~conflict & (local_ok | remote_ok);

  wire logic fwd_req = (local_ok & hw_rise.run_forward_cmd) | (remote_ok & cmd_w.fwd);
  wire logic rev_req = is_rev_type
                     & ((local_ok & hw_rise.run_reverse_cmd) | (remote_ok & cmd_w.rev));
  wire logic stop_req = ~drawer_ready | (remote_ok & cmd_w.stop);
  wire logic fault_clr = hw.reset_alarm | fieldbus_reset_telegram_i | cmd_w.fault_clear;

  wire logic xfer_tick = (xfer_pre_reg == 32'(MS_CYCLES - 1));
  wire logic xfer_done = (xfer_ms_reg >= delay_reg);
  wire logic flash_tick = (flash_pre_reg == 32'(MS_CYCLES - 1));
  wire logic flash_wrap = flash_tick & (flash_ms_reg == 16'(FLASH_HALF_MS - 1));

  always_comb begin
    state_next = state_reg;
    tgt_next = tgt_reg;
    case (state_reg)
      ST_OFF: begin
        if (!stop_req && fwd_req) begin
          state_next = ST_FWD;
        end else if (!stop_req && rev_req) begin
          state_next = ST_REV;
        end
      end
      ST_FWD: begin
        if (stop_req) begin
          state_next = ST_OFF;
        end else if (rev_req && typ_reg.switch_allow) begin
          state_next = ST_XFER;
          tgt_next = ST_REV;
        end
      end
      ST_REV: begin
        if (stop_req) begin
          state_next = ST_OFF;
        end else if (fwd_req && typ_reg.switch_allow) begin
          state_next = ST_XFER;
          tgt_next = ST_FWD;
        end
      end
      ST_XFER: begin
        if (stop_req) begin
          state_next = ST_OFF;
        end else if (xfer_done) begin
          state_next = tgt_reg;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // relays follow the next state so contactors and state line up
  wire logic run_f = (state_next == ST_FWD);
  wire logic run_r = (state_next == ST_REV);
  assign relay_next.rly41 = run_f;
  // single direction: feedback or redundancy contactor, both follow the run
  assign relay_next.rly43 = is_rev_type ? run_r : run_f;
  assign relay_next.rly45 = ~LARGE_VARIANT ? fault_reg
                          : is_rev_type ? (run_f | run_r)
                          : (warning_i | (fault_reg & flash_reg));
  assign relay_next.rly22 = LARGE_VARIANT & local_ok;
  assign relay_next.rly23 = LARGE_VARIANT & run_f;
  assign relay_next.rly24 = LARGE_VARIANT & (is_rev_type ? run_r : warning_i);
  assign relay_next.rly25 = LARGE_VARIANT & (drawer_ready | (ident_reg & flash_reg));
  assign relay_next.rly26 = LARGE_VARIANT & fault_reg;
  assign relay_o = relay_reg;

  assign status = '{rsvd: 23'h000000, trip: trip, fault: fault_reg, conflict: conflict,
                    remote_ok: remote_ok, local_ok: local_ok, drawer_ready: drawer_ready,
                    xfer: (state_reg == ST_XFER), rev: (state_reg == ST_REV),
                    fwd: (state_reg == ST_FWD)};
  // unmapped addresses are acked and read as zero
  wire logic [31:0] rd_mux = (wb_adr_i == ADDR_STARTER_CFG) ? 32'(cfg_reg)
                           : (wb_adr_i == ADDR_TYPICAL) ? 32'(typ_reg)
                           : (wb_adr_i == ADDR_XFER_DELAY) ? {16'h0000, delay_reg}
                           : (wb_adr_i == ADDR_COMMAND) ? {7'h00, ident_reg, 24'h000000}
                           : (wb_adr_i == ADDR_STATUS) ? 32'(status)
                           : (wb_adr_i == ADDR_POLARITY) ? {21'h000000, pol_reg}
                           : 32'h0000_0000;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      rdat_reg <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_reg <= acl_cfg_s'(CFG_RESET);
      typ_reg <= acl_typ_s'(TYP_RESET);
      delay_reg <= DLY_RESET[15:0];
      pol_reg <= HWIN_DEFAULT_POL;
      ident_reg <= 1'b0;
    end else begin
      if (wr_cfg) cfg_reg <= acl_cfg_s'(cfg_wval);
      if (wr_typ && cfg_open) typ_reg <= acl_typ_s'(merge(typ_reg, wb_dat_i, wb_sel_i, TYP_WMASK));
      if (wr_dly && cfg_open) delay_reg <= 16'(merge({16'h0000, delay_reg}, wb_dat_i, wb_sel_i,
                                                     DLY_WMASK));
      if (wr_pol && pol_open) pol_reg <= 11'(merge({21'h000000, pol_reg}, wb_dat_i, wb_sel_i,
                                                   POL_WMASK));
      if (wr_cmd && wb_sel_i[3]) ident_reg <= cmd_w.identify;
    end
  end

  // pins settle through two stages; the first feeds only the second
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      hw_prev_reg <= '0;
    end else begin
      sync1_reg <= hw_pins_i;
      sync2_reg <= sync1_reg;
      hw_prev_reg <= hw;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fb_loc_reg <= 1'b0;
      fb_rem_reg <= 1'b0;
      ser_loc_reg <= 1'b0;
      ser_rem_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (fieldbus_control_valid_i) begin
        fb_loc_reg <= fieldbus_control_telegram_i[TGM_LOCAL_BIT];
        fb_rem_reg <= fieldbus_control_telegram_i[TGM_REMOTE_BIT];
      end
      ser_loc_reg <= cmd_w.coil_local | (ser_loc_reg & ~cmd_w.coil_remote);
      ser_rem_reg <= cmd_w.coil_remote | (ser_rem_reg & ~cmd_w.coil_local);
      // a new fault in the clearing cycle is kept
      fault_reg <= hw.ext_fault | (fault_reg & ~fault_clr);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_OFF;
      tgt_reg <= ST_OFF;
      relay_reg <= '0;
    end else begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      relay_reg <= relay_next;
    end
  end

  // transfer timer restarts on every entry to the transfer state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      xfer_pre_reg <= 32'h0000_0000;
      xfer_ms_reg <= 16'h0000;
    end else if (state_reg != ST_XFER) begin
      xfer_pre_reg <= 32'h0000_0000;
      xfer_ms_reg <= 16'h0000;
    end else begin
      xfer_pre_reg <= xfer_tick ? 32'h0000_0000 : xfer_pre_reg + 32'h0000_0001;
      if (xfer_tick) xfer_ms_reg <= xfer_ms_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flash_pre_reg <= 32'h0000_0000;
      flash_ms_reg <= 16'h0000;
      flash_reg <= 1'b0;
    end else begin
      flash_pre_reg <= flash_tick ? 32'h0000_0000 : flash_pre_reg + 32'h0000_0001;
      if (flash_wrap) flash_ms_reg <= 16'h0000;
      else if (flash_tick) flash_ms_reg <= flash_ms_reg + 16'h0001;
      if (flash_wrap) flash_reg <= ~flash_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_xfer_entry;
    (state_reg == ST_FWD || state_reg == ST_REV) ##1 (state_reg == ST_XFER);
  endsequence
  sequence s_fwd_running;
    (state_reg == ST_FWD) ##0 relay_reg.rly41;
  endsequence

  property p_ready_gate;
    (state_reg == ST_OFF) && !drawer_ready |=> (state_reg == ST_OFF) && !relay_reg.rly41;
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("start without drawer ready");
  property p_exclusive;
    !(relay_reg.rly41 && is_rev_type && relay_reg.rly43);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("both contactors on");
  property p_stop_first;
    stop_req |=> (state_reg == ST_OFF) && !relay_reg.rly41 && !(is_rev_type && relay_reg.rly43);
  endproperty
  a_stop_first: assert property (p_stop_first) else $error("stop did not win");
  property p_conflict;
    conflict |-> !drawer_ready;
  endproperty
  a_conflict: assert property (p_conflict) else $error("ready with local and remote");
  property p_supv;
    typ_reg.supv_en && !hw.drawer_sup |-> !drawer_ready;
  endproperty
  a_supv: assert property (p_supv) else $error("ready without drawer supervision");
  property p_cfg_lock;
    wr_typ && !cfg_reg.param_allow |=> $stable(typ_reg);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("locked setting changed");
  property p_fwd_start;
    (state_reg == ST_OFF) && fwd_req && !stop_req |=> s_fwd_running;
  endproperty
  a_fwd_start: assert property (p_fwd_start) else $error("forward start missed");
  property p_switch_refused;
    (state_reg == ST_FWD) && rev_req && !typ_reg.switch_allow && !stop_req
      |=> (state_reg == ST_FWD) [*2];
  endproperty
  a_switch_refused: assert property (p_switch_refused) else $error("switchover taken");
  property p_xfer_dead;
    s_xfer_entry |-> !relay_reg.rly41 && !relay_reg.rly43;
  endproperty
  a_xfer_dead: assert property (p_xfer_dead) else $error("contactor on in transfer");
  property p_xfer_hold;
    (state_reg == ST_XFER) && !xfer_done && !stop_req |=> (state_reg == ST_XFER);
  endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("transfer delay cut short");
  property p_coil;
    cmd_w.coil_local && !cmd_w.coil_remote |=> ser_loc_reg && !ser_rem_reg;
  endproperty
  a_coil: assert property (p_coil) else $error("coil local not taken");
endmodule

// ---- verification/acl_field_model.sv ----
module acl_field_model (
  input wire logic clk_i,
  input wire acl_pkg::acl_relay_s relay_i,
  input wire acl_pkg::acl_hwin_s want_i,
  output acl_pkg::acl_hwin_s pins_o,
  output logic short_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import acl_pkg::*;
  logic [1:0] coil_reg;
  assign pins_o = acl_hwin_s'(want_i ^ HWIN_DEFAULT_POL);
  // contacts follow coils a cycle late
  always_ff @(posedge clk_i) begin
    coil_reg <= {relay_i.rly41, relay_i.rly43};
  end
  // both closed means a line-to-line short
  assign short_o = &coil_reg;
endmodule

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acl_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic lvl;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic wb_ack;
  acl_hwin_s want = '0;
  acl_hwin_s pins;
  logic [15:0] tgm = 16'h0;
  logic tgm_v = 1'b0;
  logic fb_rst = 1'b0;
  logic warn = 1'b0;
  logic short_c;
  acl_relay_s rly;
  acl_status_s st;
  int n_fail = 0;
  int num_checks = 0;
  int cyc_cnt = 0;

  always #2.5 clk_i = ~clk_i;

  // short counts keep the switchover wait at 2*4+1 cycles
  acl_starter_ctrl #(.MS_CYCLES(4), .FLASH_HALF_MS(2), .LARGE_VARIANT(1'b1)) i_acl_starter_ctrl (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .hw_pins_i(pins), .fieldbus_control_telegram_i(tgm),
    .fieldbus_control_valid_i(tgm_v), .fieldbus_reset_telegram_i(fb_rst),
    .warning_i(warn), .relay_o(rly));

  acl_field_model i_acl_field_model (.clk_i(clk_i), .relay_i(rly), .want_i(want),
    .pins_o(pins), .short_o(short_c));

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    wb_sel <= 4'hf;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_sel <= 4'h0;
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask

  task automatic stat();
    wb(1'b0, ADDR_STATUS, 32'h0);
    st = acl_status_s'(rd);
  endtask

  task automatic rel(input logic [1:0] exp);
    chk(32'({rly.rly41, rly.rly43}), 32'(exp));
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pulse_tgm(input logic [15:0] w);
    @(posedge clk_i);
    tgm <= w;
    tgm_v <= 1'b1;
    @(posedge clk_i);
    tgm_v <= 1'b0;
  endtask

  task automatic mode_chk(input acl_src_e src, input logic [1:0] exp);
    wb(1'b1, ADDR_TYPICAL, 32'({src, 4'h2}));
    wait_n(2);
    stat();
    chk(32'({st.local_ok, st.remote_ok}), 32'(exp));
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (!reset_i) chk(32'(short_c), 32'h0);
    // far beyond the few hundred cycles the sequence needs
    if (cyc_cnt == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    wait_n(10);
    reset_i <= 1'b0;
    rchk(ADDR_STARTER_CFG, CFG_RESET);
    rchk(ADDR_TYPICAL, TYP_RESET);
    rchk(ADDR_XFER_DELAY, DLY_RESET);
    rchk(ADDR_POLARITY, 32'(HWIN_DEFAULT_POL));
    rchk(8'h40, 32'h0);
    wb(1'b1, ADDR_TYPICAL, 32'h3);
    rchk(ADDR_TYPICAL, TYP_RESET);
    wb(1'b1, ADDR_STARTER_CFG, 32'h2);
    wb(1'b1, ADDR_STARTER_CFG, 32'h103);
    rchk(ADDR_STARTER_CFG, 32'h103);
    wb(1'b1, ADDR_POLARITY, 32'h0);
    rchk(ADDR_POLARITY, 32'(HWIN_DEFAULT_POL));
    wb(1'b1, ADDR_XFER_DELAY, 32'h2);
    rchk(ADDR_XFER_DELAY, 32'h2);
    want.mode_local <= 1'b1;
    want.mode_remote <= 1'b1;
    wait_n(8);
    stat();
    chk(32'({st.drawer_ready, st.conflict}), 32'h1);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    rel(2'b00);
    want.mode_local <= 1'b0;
    wait_n(8);
    stat();
    chk(32'({st.drawer_ready, st.local_ok, st.remote_ok}), 32'h5);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    rel(2'b10);
    chk(32'(rly.rly45), 32'h1);
    wb(1'b1, ADDR_COMMAND, 32'h2);
    rel(2'b10);
    wb(1'b1, ADDR_COMMAND, 32'h4);
    rel(2'b00);
    wb(1'b1, ADDR_COMMAND, 32'h5);
    rel(2'b00);
    wb(1'b1, ADDR_COMMAND, 32'h2);
    rel(2'b01);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    rel(2'b01);
    wb(1'b1, ADDR_COMMAND, 32'h4);
    wb(1'b1, ADDR_TYPICAL, 32'h21);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    wb(1'b1, ADDR_COMMAND, 32'h2);
    rel(2'b00);
    wait_n(6);
    rel(2'b00);
    wait_n(4);
    rel(2'b01);
    wb(1'b1, ADDR_COMMAND, 32'h4);
    want.mode_remote <= 1'b0;
    want.mode_local <= 1'b1;
    wait_n(8);
    want.run_forward_cmd <= 1'b1;
    wait_n(6);
    rel(2'b10);
    chk(32'({rly.rly22, rly.rly23}), 32'h3);
    wb(1'b1, ADDR_COMMAND, 32'h4);
    rel(2'b10);
    want.stop <= 1'b1;
    wait_n(6);
    rel(2'b00);
    want.stop <= 1'b0;
    want.run_forward_cmd <= 1'b0;
    wb(1'b1, ADDR_TYPICAL, 32'h22);
    wait_n(6);
    stat();
    chk(32'(st.drawer_ready), 32'h0);
    want.drawer_sup <= 1'b1;
    want.ext_fault <= 1'b1;
    wait_n(6);
    stat();
    chk(32'({st.fault, st.drawer_ready}), 32'h2);
    want.ext_fault <= 1'b0;
    want.reset_alarm <= 1'b1;
    wait_n(6);
    want.reset_alarm <= 1'b0;
    wait_n(6);
    stat();
    chk(32'({st.fault, st.drawer_ready}), 32'h1);
    pulse_tgm(16'h0400);
    mode_chk(SRC_FIELDBUS, 2'b01);
    pulse_tgm(16'h0200);
    mode_chk(SRC_FIELDBUS, 2'b10);
    wb(1'b1, ADDR_COMMAND, 32'h200);
    mode_chk(SRC_SERIAL, 2'b01);
    wb(1'b1, ADDR_COMMAND, 32'h100);
    mode_chk(SRC_SERIAL, 2'b10);
    mode_chk(SRC_FIXED_LOCAL, 2'b10);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    rel(2'b00);
    mode_chk(SRC_FIXED_REMOTE, 2'b01);
    want.run_forward_cmd <= 1'b1;
    wait_n(6);
    rel(2'b00);
    wb(1'b1, ADDR_COMMAND, 32'h1);
    rel(2'b10);
    wb(1'b1, ADDR_COMMAND, 32'h4);
    // ready steady wins, identify flashes only without ready
    chk(32'({rly.rly22, rly.rly25, rly.rly26}), 32'h2);
    wb(1'b1, ADDR_COMMAND, 32'h0100_0000);
    want.drawer_sup <= 1'b0;
    wait_n(6);
    lvl = rly.rly25;
    wait_n(8);
    chk(32'(rly.rly25 ^ lvl), 32'h1);
    want.drawer_sup <= 1'b1;
    wait_n(6);
    chk(32'(rly.rly25), 32'h1);
    wait_n(8);
    chk(32'(rly.rly25), 32'h1);
    wb(1'b1, ADDR_COMMAND, 32'h0);
    want.ext_fault <= 1'b1;
    wait_n(6);
    want.ext_fault <= 1'b0;
    wait_n(6);
    chk(32'({rly.rly25, rly.rly26}), 32'h1);
    fb_rst <= 1'b1;
    wait_n(1);
    fb_rst <= 1'b0;
    wait_n(2);
    chk(32'({rly.rly25, rly.rly26}), 32'h2);
    // single direction map: warning steady over flashing failure
    wb(1'b1, ADDR_STARTER_CFG, 32'h3);
    warn <= 1'b1;
    wait_n(2);
    chk(32'({rly.rly45, rly.rly24}), 32'h3);
    want.ext_fault <= 1'b1;
    wait_n(6);
    chk(32'(rly.rly45), 32'h1);
    wait_n(8);
    chk(32'(rly.rly45), 32'h1);
    warn <= 1'b0;
    wait_n(2);
    lvl = rly.rly45;
    wait_n(8);
    chk(32'(rly.rly45 ^ lvl), 32'h1);
    summarize();
  end
endmodule
